// ### design/htfs_pkg.sv
// ************************************************************
// transmit fifo status package
// ************************************************************
`default_nettype none
package htfs_pkg;

  // ************************************************************
  // register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [7:0] IDX_CTRL       = 8'ha0;
  localparam logic [7:0] IDX_WRITE_PORT = 8'ha2;
  localparam logic [7:0] IDX_LEVEL_STAT = 8'ha4;
  localparam logic [7:0] IDX_EVT_LATCH  = 8'ha6;
  localparam logic [7:0] IDX_EVT_ENABLE = 8'ha8;
  localparam logic [7:0] IDX_PORT_GATE  = 8'haa;
  localparam int         ADDR_W         = 12;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BIT_FLUSH      = 0;
  localparam int BIT_MSB_FIRST  = 3;
  localparam int THR_LSB        = 8;
  localparam int THR_W          = 5;
  localparam int BYTE_LSB       = 8;
  localparam int BIT_LAST_MARK  = 0;
  localparam int GRP_LSB        = 8;
  localparam int GRP_W          = 6;
  localparam int BIT_FULL       = 2;
  localparam int BIT_EMPTY      = 1;
  localparam int BIT_SPACE_OK   = 0;
  localparam int BIT_OVERFLOW   = 5;
  localparam int BIT_UNDERFLOW  = 4;
  localparam int BIT_PKT_END    = 3;
  localparam int BIT_GATE       = 0;

  // ************************************************************
  // reset values and masks
  // ************************************************************
  localparam logic [4:0]  THR_RESET    = 5'h08;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [5:0]  EVT_MASK     = 6'h3b;
  localparam logic [5:0]  ENABLE_MASK  = 6'h3f;

  // ************************************************************
  // fifo and serial defaults
  // ************************************************************
  localparam int FIFO_DEPTH = 256;
  localparam int BIT_DIV    = 8;

  typedef enum logic [1:0] {
    SEND_IDLE  = 2'b01,
    SEND_SHIFT = 2'b10
  } htfs_send_t;

endpackage : htfs_pkg
`default_nettype wire

// ### design/htfs_tx_fifo.sv
// Overview of operation
// - bytes leave lsb first, or msb first selected
// - status shows free space in eight-byte groups
// - full bit set only at full fifo
// - empty bit set only with no bytes
// - space bit follows free space versus threshold
// - overflow flag latches on write to full
// - underflow flag latches when sending starves mid-packet
// - packet end flag latches when marker leaves
// - empty flag latches on empty rising
// - space flag latches on space rising
// - flush release sets empty and space flags
// - interrupt needs flag enable and port gate
// - full enable bit stored but unused
// - upper byte write pushes; reads give zero
// - threshold is level times eight plus one
// - flush empties, halts sender, drops writes
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module htfs_tx_fifo
  import htfs_pkg::*;
#(
  parameter int DEPTH  = FIFO_DEPTH,
  parameter int DIV    = BIT_DIV
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // serial side
  output logic                     txBitStrobe,
  output logic                     txBitData,
  output logic                     txBusy,
  // interrupt
  output logic                     irq
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [ADDR_W-1:0] byteAddr(input logic [7:0] idx);
    byteAddr = {2'b00, idx, 2'b00};
  endfunction : byteAddr

  function automatic logic [7:0] reverseByte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      reverseByte[i] = b[7-i];
    end
  endfunction : reverseByte

  localparam int                CNT_W   = $clog2(DEPTH) + 1;
  localparam int                PTR_W   = $clog2(DEPTH);
  localparam logic [CNT_W-1:0]  DEPTH_C = CNT_W'(DEPTH);
  localparam int                DIV_W   = $clog2(DIV) + 1;

  // ************************************************************
  // apb decode
  // ************************************************************
  logic              setupPh;
  logic              wrEn;
  logic              hitCtrl;
  logic              hitPort;
  logic              hitStat;
  logic              hitLatch;
  logic              hitEnable;
  logic              hitGate;
  logic              mapped;

  assign pready    = 1'b1;
  assign setupPh   = psel && !penable;
  assign wrEn      = psel && penable && pwrite;
  assign hitCtrl   = paddr == byteAddr(IDX_CTRL);
  assign hitPort   = paddr == byteAddr(IDX_WRITE_PORT);
  assign hitStat   = paddr == byteAddr(IDX_LEVEL_STAT);
  assign hitLatch  = paddr == byteAddr(IDX_EVT_LATCH);
  assign hitEnable = paddr == byteAddr(IDX_EVT_ENABLE);
  assign hitGate   = paddr == byteAddr(IDX_PORT_GATE);
  assign mapped    = hitCtrl || hitPort || hitStat || hitLatch || hitEnable || hitGate;

  // ************************************************************
  // control registers
  // ************************************************************
  logic              flush;
  logic              flushDly;
  logic              msbFirst;
  logic [THR_W-1:0]  thrLevel;
  logic [5:0]        evtEnable;
  logic              portGate;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flush    <= 1'b0;
      msbFirst <= 1'b0;
      thrLevel <= THR_RESET;
    end else if (wrEn && hitCtrl) begin
      if (pstrb[0]) begin
        flush    <= pwdata[BIT_FLUSH];
        msbFirst <= pwdata[BIT_MSB_FIRST];
      end
      if (pstrb[1]) begin
        thrLevel <= pwdata[THR_LSB +: THR_W];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      evtEnable <= ENABLE_RESET[5:0];
      portGate  <= 1'b0;
    end else begin
      if (wrEn && hitEnable && pstrb[0]) begin
        evtEnable <= pwdata[5:0] & ENABLE_MASK;
      end
      if (wrEn && hitGate && pstrb[0]) begin
        portGate <= pwdata[BIT_GATE];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flushDly <= 1'b0;
    end else begin
      flushDly <= flush;
    end
  end

  // ************************************************************
  // fifo storage
  // ************************************************************
  logic [8:0]        fifoMem [DEPTH];
  logic [PTR_W-1:0]  wrPtr;
  logic [PTR_W-1:0]  rdPtr;
  logic [CNT_W-1:0]  count;
  logic              pushReq;
  logic              push;
  logic              pop;
  logic [8:0]        popWord;
  logic [CNT_W-1:0]  freeBytes;
  logic [CNT_W-1:0]  thrBytes;
  logic              txFull;
  logic              txEmpty;
  logic              txSpaceOk;
  logic [GRP_W-1:0]  txFreeGroups;

  // writes are dropped while flushing
  assign pushReq      = wrEn && hitPort && pstrb[1] && !flush;
  assign push         = pushReq && !txFull;
  assign popWord      = fifoMem[rdPtr];
  assign freeBytes    = DEPTH_C - count;
  assign thrBytes     = CNT_W'({thrLevel, 3'b000}) + CNT_W'(1);
  assign txFull       = count == DEPTH_C;
  assign txEmpty      = count == '0;
  assign txSpaceOk    = freeBytes >= thrBytes;
  assign txFreeGroups = GRP_W'(freeBytes >> 3);

  always_ff @(posedge clk) begin
    if (push) begin
      fifoMem[wrPtr] <= {pwdata[BYTE_LSB +: 8], pwdata[BIT_LAST_MARK]};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + PTR_W'(1);
      end
      if (pop) begin
        rdPtr <= rdPtr + PTR_W'(1);
      end
      count <= count + CNT_W'(push) - CNT_W'(pop);
    end
  end

  // ************************************************************
  // bit-rate divider and serialiser
  // ************************************************************
  htfs_send_t        sendState;
  logic [DIV_W-1:0]  divCnt;
  logic              bitTick;
  logic [7:0]        shiftReg;
  logic [2:0]        bitCnt;
  logic              inPacket;
  logic              lastBit;
  logic              underflowEvt;

  assign bitTick      = divCnt == DIV_W'(DIV - 1);
  assign lastBit      = bitCnt == 3'h7;
  // a pop happens only on a tick when the previous byte is done
  assign pop          = bitTick && !txEmpty && !flush
                        && (sendState == SEND_IDLE || lastBit);
  // starving mid-packet loses the packet tail
  assign underflowEvt = bitTick && !flush && sendState == SEND_SHIFT && lastBit
                        && txEmpty && inPacket;
  assign txBusy       = sendState == SEND_SHIFT;

  always_ff @(posedge clk) begin
    if (!rst_b || bitTick) begin
      divCnt <= '0;
    end else begin
      divCnt <= divCnt + DIV_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || flush) begin
      sendState <= SEND_IDLE;
      bitCnt    <= 3'h0;
      shiftReg  <= 8'h00;
      inPacket  <= 1'b0;
    end else if (bitTick) begin
      unique case (sendState)
        SEND_IDLE: begin
          if (pop) begin
            sendState <= SEND_SHIFT;
          end
        end
        SEND_SHIFT: begin
          bitCnt   <= bitCnt + 3'h1;
          shiftReg <= {1'b0, shiftReg[7:1]};
          if (lastBit && !pop) begin
            sendState <= SEND_IDLE;
          end
        end
      endcase
      if (pop) begin
        // order fixed at load so the shifter always sends bit 0
        shiftReg <= msbFirst ? reverseByte(popWord[8:1]) : popWord[8:1];
        bitCnt   <= 3'h0;
        inPacket <= !popWord[0];
      end else if (underflowEvt) begin
        inPacket <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txBitStrobe <= 1'b0;
      txBitData   <= 1'b0;
    end else begin
      txBitStrobe <= bitTick && !flush && sendState == SEND_SHIFT;
      if (bitTick && sendState == SEND_SHIFT) begin
        txBitData <= shiftReg[0];
      end
    end
  end

  // ************************************************************
  // event latches and interrupt
  // ************************************************************
  logic        emptyDly;
  logic        spaceDly;
  logic [5:0]  evtSet;
  logic [5:0]  evtClr;
  logic [5:0]  evtLatch;
  logic        flushRelease;

  assign flushRelease = flushDly && !flush;

  always_comb begin
    evtSet                = 6'h00;
    evtSet[BIT_OVERFLOW]  = pushReq && txFull;
    evtSet[BIT_UNDERFLOW] = underflowEvt;
    evtSet[BIT_PKT_END]   = pop && popWord[0];
    evtSet[BIT_EMPTY]     = (txEmpty && !emptyDly) || flushRelease;
    evtSet[BIT_SPACE_OK]  = (txSpaceOk && !spaceDly) || flushRelease;
  end

  assign evtClr = (wrEn && hitLatch && pstrb[0]) ? pwdata[5:0] : 6'h00;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      emptyDly <= 1'b1;
      spaceDly <= 1'b1;
      evtLatch <= 6'h00;
    end else begin
      emptyDly <= txEmpty;
      spaceDly <= txSpaceOk;
      // set beats a clear in the same cycle
      evtLatch <= ((evtLatch & ~evtClr) | evtSet) & EVT_MASK;
    end
  end

  assign irq = portGate && |(evtLatch & evtEnable & EVT_MASK);

  // ************************************************************
  // read data
  // ************************************************************
  logic [15:0] rdWord;

  always_comb begin
    rdWord = 16'h0000;
    if (hitCtrl) begin
      rdWord[BIT_FLUSH]             = flush;
      rdWord[BIT_MSB_FIRST]         = msbFirst;
      rdWord[THR_LSB +: THR_W]      = thrLevel;
    end else if (hitStat) begin
      rdWord[GRP_LSB +: GRP_W]      = txFreeGroups;
      rdWord[BIT_FULL]              = txFull;
      rdWord[BIT_EMPTY]             = txEmpty;
      rdWord[BIT_SPACE_OK]          = txSpaceOk;
    end else if (hitLatch) begin
      rdWord[5:0]                   = evtLatch;
    end else if (hitEnable) begin
      rdWord[5:0]                   = evtEnable;
    end else if (hitGate) begin
      rdWord[BIT_GATE]              = portGate;
    end
  end

  // sampled in setup so the access phase needs no wait state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setupPh) begin
      prdata  <= {16'h0000, rdWord};
      pslverr <= !mapped;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_fullWrite;
    pushReq && txFull;
  endsequence

  sequence s_flushRelease;
    flush ##1 !flush;
  endsequence

  sequence s_markerLeaves;
    pop && popWord[0];
  endsequence

  overflow_latch_a: assert property (s_fullWrite |=>
    evtLatch[BIT_OVERFLOW] && $stable(wrPtr))
    else $error("overflow not latched");

  flag_hold_a: assert property (
    evtLatch[BIT_OVERFLOW] && !(evtClr[BIT_OVERFLOW]) |=> evtLatch[BIT_OVERFLOW])
    else $error("overflow flag lost without clear");

  flush_empty_a: assert property (flush |=> txEmpty && !txBusy && !txBitStrobe)
    else $error("flush did not empty fifo");

  flush_release_a: assert property (s_flushRelease |=>
    evtLatch[BIT_EMPTY] && evtLatch[BIT_SPACE_OK])
    else $error("flush release flags missing");

  empty_edge_a: assert property ($rose(txEmpty) |=> evtLatch[BIT_EMPTY])
    else $error("empty edge not latched");

  space_edge_a: assert property ($rose(txSpaceOk) |=> evtLatch[BIT_SPACE_OK])
    else $error("space edge not latched");

  pkt_end_a: assert property (s_markerLeaves |=>
    evtLatch[BIT_PKT_END] ##1 !txBitStrobe [*1])
    else $error("packet end not latched");

  underflow_latch_a: assert property (underflowEvt |=>
    evtLatch[BIT_UNDERFLOW] && !inPacket)
    else $error("underflow not latched");

  irq_gate_a: assert property (irq |-> portGate && (evtLatch & evtEnable) != 6'h00
    && $past(rst_b))
    else $error("interrupt without enable");

  space_thr_a: assert property (txSpaceOk == (freeBytes > CNT_W'({thrLevel, 3'b000}))
    && txFull == (freeBytes == '0))
    else $error("threshold or full mismatch");

endmodule : htfs_tx_fifo
`default_nettype wire

// ### testbench/tb_hdlc_tx_fifo_status.sv
`timescale 1ns/1ps
`default_nettype none
module tb_hdlc_tx_fifo_status;
  import htfs_pkg::*;
  // ********
  // setup
  // ********
  localparam int                TB_DIV = 200;
  localparam logic [ADDR_W-1:0] A_CTRL = ADDR_W'({IDX_CTRL, 2'b00});
  localparam logic [ADDR_W-1:0] A_WP   = ADDR_W'({IDX_WRITE_PORT, 2'b00});
  localparam logic [ADDR_W-1:0] A_STAT = ADDR_W'({IDX_LEVEL_STAT, 2'b00});
  localparam logic [ADDR_W-1:0] A_LAT  = ADDR_W'({IDX_EVT_LATCH, 2'b00});
  localparam logic [ADDR_W-1:0] A_EN   = ADDR_W'({IDX_EVT_ENABLE, 2'b00});
  localparam logic [ADDR_W-1:0] A_GATE = ADDR_W'({IDX_PORT_GATE, 2'b00});
  localparam logic [31:0]       ALL    = 32'hffffffff;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic        e;
  } htfs_exp_t;
  logic              clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic              txBitStrobe, txBitData, txBusy, irq, watchBits;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, lfsr;
  logic [3:0]        pstrb;
  htfs_exp_t         rdQ[$];
  logic              bitQ[$];
  int                nErrors = 0;
  int                samplesChecked = 0;

  // slow bit divider keeps the sender from draining while the fifo fills
  htfs_tx_fifo #(.DEPTH(FIFO_DEPTH), .DIV(TB_DIV)) uut (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .txBitStrobe(txBitStrobe), .txBitData(txBitData),
    .txBusy(txBusy), .irq(irq));

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // ********
  // tasks
  // ********
  function automatic logic [31:0] lfsrNext(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsrNext

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nErrors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stopTest();
    $display("checked %0d mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stopTest

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'h3;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      nErrors++;
      $display("[FAIL] %0t no ready", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic err);
    rdQ.push_back('{e, m, err});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic wb(input logic mk, input logic msb, input logic send);
    logic [7:0] b;
    b = lfsr[7:0];
    lfsr = lfsrNext(lfsr);
    if (send)
      for (int k = 0; k < 8; k++) bitQ.push_back(msb ? b[7-k] : b[k]);
    wr(A_WP, {16'h0, b, 7'h0, mk});
  endtask : wb

  // sampled mid-cycle, then back on the rising edge so the next drive starts there
  task automatic chkIrq(input logic e);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge clk);
  endtask : chkIrq

  // ********
  // monitor
  // ********
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && rdQ.size() > 0) begin
      chk(prdata & rdQ[0].m, rdQ[0].d);
      chk({31'h0, pslverr}, {31'h0, rdQ[0].e});
      void'(rdQ.pop_front());
    end
    if (watchBits && txBitStrobe === 1'b1) begin
      if (bitQ.size() == 0)
        chk(32'h1, 32'h0);
      else
        chk({31'h0, txBitData}, {31'h0, bitQ.pop_front()});
    end
  end

  initial begin
    repeat (50000) @(posedge clk);
    nErrors++;
    $display("[FAIL] %0t watchdog expired", $time);
    stopTest();
  end

  // ********
  // sequence
  // ********
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    lfsr = 32'hbf44;
    watchBits = 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(A_STAT, 32'h2003, ALL, 1'b0);
    rd(A_LAT, 32'h0, ALL, 1'b0);
    rd(A_EN, 32'h0, ALL, 1'b0);
    rd(A_WP, 32'h0, ALL, 1'b0);
    rd(12'h2b0, 32'h0, ALL, 1'b1);
    wr(A_EN, 32'h3f);
    rd(A_EN, 32'h3f, ALL, 1'b0);
    wr(A_GATE, 32'h1);
    rd(A_GATE, 32'h1, ALL, 1'b0);
    // one byte goes to the sender, so the fifo count is exact while filling
    wb(1'b0, 1'b0, 1'b0);
    repeat (250) @(posedge clk);
    wr(A_LAT, 32'h3f);
    for (int i = 1; i <= 256; i++) begin
      wb(1'b0, 1'b0, 1'b0);
      if (i == 191) rd(A_STAT, 32'h0801, ALL, 1'b0);
      if (i == 192) rd(A_STAT, 32'h0800, ALL, 1'b0);
      if (i == 255) rd(A_STAT, 32'h0000, ALL, 1'b0);
    end
    rd(A_STAT, 32'h0004, ALL, 1'b0);
    chkIrq(1'b0);
    wb(1'b0, 1'b0, 1'b0);
    rd(A_LAT, 32'h20, 32'h3b, 1'b0);
    chkIrq(1'b1);
    wr(A_LAT, 32'h0);
    rd(A_LAT, 32'h20, 32'h3b, 1'b0);
    wr(A_LAT, 32'h20);
    rd(A_LAT, 32'h0, 32'h3b, 1'b0);
    chkIrq(1'b0);
    // flush while full, with a write that must be dropped
    wr(A_CTRL, 32'h0801);
    wb(1'b0, 1'b0, 1'b0);
    rd(A_STAT, 32'h2003, ALL, 1'b0);
    chk({31'h0, txBusy}, 32'h0);
    wr(A_LAT, 32'h3f);
    wr(A_CTRL, 32'h0800);
    rd(A_LAT, 32'h03, 32'h3b, 1'b0);
    wr(A_GATE, 32'h0);
    chkIrq(1'b0);
    wr(A_GATE, 32'h1);
    chkIrq(1'b1);
    wr(A_EN, 32'h04);
    chkIrq(1'b0);
    wr(A_LAT, 32'h3f);
    // two bytes lsb first, second marks the packet end
    watchBits = 1'b1;
    wb(1'b0, 1'b0, 1'b1);
    wb(1'b1, 1'b0, 1'b1);
    repeat (3800) @(posedge clk);
    rd(A_LAT, 32'h0a, 32'h1a, 1'b0);
    wr(A_LAT, 32'h3f);
    // lone unmarked byte msb first starves the sender
    wr(A_CTRL, 32'h0808);
    rd(A_CTRL, 32'h0808, ALL, 1'b0);
    wb(1'b0, 1'b1, 1'b1);
    repeat (2000) @(posedge clk);
    rd(A_LAT, 32'h12, 32'h1a, 1'b0);
    repeat (20) @(posedge clk);
    chk(32'(bitQ.size() + rdQ.size()), 32'h0);
    stopTest();
  end
endmodule : tb_hdlc_tx_fifo_status
`default_nettype wire
